// ---- design/crs_pkg.sv ----
// Package: constants, types and carriers for the CPU register set
//------------------------------------------------------------------------------
// Overview of operation
// - Primary accumulator is 16 bits, low byte usable alone, main operand register.
// - Accumulators work 16 bits wide when data length flag is 0, 8 when 1.
// - Secondary accumulator does the same as the primary one.
// - Both index registers 16 bits, low byte alone in writes and indexed sums when index length flag is 1.
// - Indexed modes add the selected index register to the base address.
// - Block transfer source is instruction third byte over first index register.
// - Block transfer destination is instruction second byte over second index register.
// - Stack pointer is 16 bits, used by calls, interrupts and stack modes.
// - Program counter holds low 16 bits of next program address.
// - Program bank holds high byte and increments on program counter carry.
// - Branch offset carry or borrow increments or decrements the program bank.
// - Data bank supplies high byte of the 24-bit address in listed modes.
// - Direct page base sets a 256-byte page, crossing into bank 1 from FF01.
// - Direct modes use the page base; low byte zero gives fewest cycles.
// - Processor status is 11 bits: result and mode flags plus interrupt level.
// - Conditional branches test carry, zero, overflow and negative flags.
// - Carry takes ALU carry or borrow, and shift or rotate results.
// - Carry set or cleared by dedicated and generic status-bit instructions.
// - Zero set when result is zero, else cleared; generic set and clear too.
// - Interrupt disable blocks all but watchdog, debug and software interrupts.
// - Accepting an interrupt sets the interrupt disable flag.
// - Interrupt disable set or cleared by dedicated and generic instructions.
//------------------------------------------------------------------------------
package crs_pkg;

	// Register indices on the software port
	localparam logic [3:0] CRS_IDX_ACC_PRI  = 4'h0;
	localparam logic [3:0] CRS_IDX_ACC_SEC  = 4'h1;
	localparam logic [3:0] CRS_IDX_INDEX1   = 4'h2;
	localparam logic [3:0] CRS_IDX_INDEX2   = 4'h3;
	localparam logic [3:0] CRS_IDX_STACK    = 4'h4;
	localparam logic [3:0] CRS_IDX_IPTR     = 4'h5;
	localparam logic [3:0] CRS_IDX_PBANK    = 4'h6;
	localparam logic [3:0] CRS_IDX_DBANK    = 4'h7;
	localparam logic [3:0] CRS_IDX_DPBASE   = 4'h8;
	localparam logic [3:0] CRS_IDX_PSTAT    = 4'h9;

	// Status register field positions
	localparam int unsigned CRS_PS_C     = 0;
	localparam int unsigned CRS_PS_Z     = 1;
	localparam int unsigned CRS_PS_I     = 2;
	localparam int unsigned CRS_PS_D     = 3;
	localparam int unsigned CRS_PS_X     = 4;
	localparam int unsigned CRS_PS_M     = 5;
	localparam int unsigned CRS_PS_V     = 6;
	localparam int unsigned CRS_PS_N     = 7;
	localparam int unsigned CRS_PS_IPL_L = 8;
	localparam int unsigned CRS_PS_IPL_H = 10;

	// Values after reset
	localparam logic [15:0] CRS_RST_WORD  = 16'h0000;
	localparam logic [7:0]  CRS_RST_BANK  = 8'h00;
	localparam logic [10:0] CRS_RST_PSTAT = 11'h004;

	// Direct page figures
	localparam logic [15:0] CRS_DP_SPAN_BASE = 16'hFF01;
	localparam logic [7:0]  CRS_DP_FAST_LOW  = 8'h00;

	typedef enum logic [2:0] {
		CRS_AG_IDX_X,
		CRS_AG_IDX_Y,
		CRS_AG_BLK_SRC,
		CRS_AG_BLK_DST,
		CRS_AG_DIRECT,
		CRS_AG_DATA_BANK,
		CRS_AG_STACK_REL
	} crs_agen_mode_t;

	typedef enum logic [1:0] {
		CRS_BR_CARRY,
		CRS_BR_ZERO,
		CRS_BR_OVF,
		CRS_BR_NEG
	} crs_br_cond_t;

	typedef struct packed {
		logic        en;
		logic [3:0]  sel;
		logic [15:0] data;
	} crs_wr_t;

	typedef struct packed {
		logic        carry_we;
		logic        carry;
		logic        nz_we;
		logic [15:0] result;
		logic        ovf_we;
		logic        ovf;
	} crs_flag_t;

	typedef struct packed {
		logic       set_carry_instruction;
		logic       clear_carry_instruction;
		logic       set_irq_disable_instruction;
		logic       clear_irq_disable_instruction;
		logic [7:0] set_mask;
		logic [7:0] clr_mask;
	} crs_psop_t;

	typedef struct packed {
		logic           en;
		crs_agen_mode_t mode;
		logic [23:0]    base;
		logic [7:0]     bank;
		logic [7:0]     offset;
	} crs_agen_t;

	typedef struct packed {
		logic [15:0] primary_accumulator;
		logic [15:0] secondary_accumulator;
		logic [15:0] first_index;
		logic [15:0] second_index;
		logic [15:0] stack_top_pointer;
		logic [15:0] instruction_pointer;
		logic [7:0]  program_bank;
		logic [7:0]  data_bank;
		logic [15:0] direct_page_base;
		logic [10:0] processor_status;
	} crs_state_t;

endpackage : crs_pkg

// ---- design/crs_cpu_register_set.sv ----
// Module: architectural register set with flag logic and address generation
`timescale 1ns/1ps

module crs_cpu_register_set
	import crs_pkg::*;
(
	input  wire logic        CLOCK_I,      // Core clock, 250 MHz
	input  wire logic        SRST_I,       // Synchronous reset, active high
	input  wire logic [3:0]  REG_ADDR_I,   // Software port register index
	input  wire logic [15:0] REG_WDATA_I,  // Software port write data
	input  wire logic        REG_WE_I,     // Software port write strobe
	input  wire logic        REG_RE_I,     // Software port read strobe
	output logic      [15:0] REG_RDATA_O,  // Read data, cycle after strobe
	input  wire crs_wr_t     EXEC_WR_I,    // Execution unit register write
	input  wire crs_flag_t   FLAG_UPD_I,   // ALU flag results
	input  wire crs_psop_t   PS_OP_I,      // Status bit instructions
	input  wire logic        PC_INC_I,     // Advance program address by one
	input  wire logic        BR_APPLY_I,   // Add branch offset to program address
	input  wire logic [15:0] BR_OFFSET_I,  // Signed branch offset
	input  wire crs_br_cond_t BR_COND_I,   // Flag tested by the branch
	input  wire logic        BR_POL_I,     // Flag value that takes the branch
	input  wire logic        BR_TEST_I,    // Evaluate the branch condition
	output logic             BR_TAKEN_O,   // Branch condition result
	input  wire crs_agen_t   AGEN_I,       // Address generation request
	output logic      [23:0] EA_O,         // Effective address
	output logic             EA_VALID_O,   // Effective address valid pulse
	output logic             DP_SLOW_O,    // Direct page needs extra cycle
	input  wire logic        IRQ_REQ_I,    // Maskable interrupt pending
	input  wire logic        IRQ_NMASK_I,  // Watchdog, debug or software pending
	input  wire logic        IRQ_ACCEPT_I, // Core accepts an interrupt
	output logic             IRQ_GRANT_O,  // Interrupt may be taken
	output crs_state_t       STATE_O       // Architectural register view
);

	//--------------------------------------------------------------------------
	// Architectural state
	//--------------------------------------------------------------------------
	logic [15:0] acc_pri;
	logic [15:0] acc_sec;
	logic [15:0] index1;
	logic [15:0] index2;
	logic [15:0] stack_ptr;
	logic [15:0] iptr;
	logic [7:0]  pbank;
	logic [7:0]  dbank;
	logic [15:0] dp_base;
	logic [10:0] pstat;

	logic        flag_m;
	logic        flag_x;
	logic        bus_wr;
	logic        ex_wr;
	logic [23:0] next_prog;
	logic [23:0] br_ext;
	logic [10:0] next_pstat;

	assign flag_m = pstat[CRS_PS_M];
	assign flag_x = pstat[CRS_PS_X];
	assign bus_wr = REG_WE_I;
	assign ex_wr  = EXEC_WR_I.en;

	// Narrow writes keep the upper byte so an 8-bit phase never corrupts it
	function automatic logic [15:0] merge_w(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic narrow);
		merge_w = narrow ? {old_v[15:8], new_v[7:0]} : new_v;
	endfunction : merge_w

	//--------------------------------------------------------------------------
	// Accumulators and index registers
	//--------------------------------------------------------------------------
	// Execution writes beat the software port only on the same register, so a
	// port write to the other register of the pair is never lost
	always_ff @(posedge CLOCK_I)
	begin
		if (SRST_I)
		begin
			acc_pri <= CRS_RST_WORD;
			acc_sec <= CRS_RST_WORD;
		end
		else
		begin
			if (ex_wr && EXEC_WR_I.sel == CRS_IDX_ACC_PRI)
				acc_pri <= merge_w(acc_pri, EXEC_WR_I.data, flag_m);
			else if (bus_wr && REG_ADDR_I == CRS_IDX_ACC_PRI)
				acc_pri <= REG_WDATA_I;
			if (ex_wr && EXEC_WR_I.sel == CRS_IDX_ACC_SEC)
				acc_sec <= merge_w(acc_sec, EXEC_WR_I.data, flag_m);
			else if (bus_wr && REG_ADDR_I == CRS_IDX_ACC_SEC)
				acc_sec <= REG_WDATA_I;
		end
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (SRST_I)
		begin
			index1 <= CRS_RST_WORD;
			index2 <= CRS_RST_WORD;
		end
		else
		begin
			if (ex_wr && EXEC_WR_I.sel == CRS_IDX_INDEX1)
				index1 <= merge_w(index1, EXEC_WR_I.data, flag_x);
			else if (bus_wr && REG_ADDR_I == CRS_IDX_INDEX1)
				index1 <= REG_WDATA_I;
			if (ex_wr && EXEC_WR_I.sel == CRS_IDX_INDEX2)
				index2 <= merge_w(index2, EXEC_WR_I.data, flag_x);
			else if (bus_wr && REG_ADDR_I == CRS_IDX_INDEX2)
				index2 <= REG_WDATA_I;
		end
	end

	//--------------------------------------------------------------------------
	// Stack pointer, data bank, direct page base
	//--------------------------------------------------------------------------
	always_ff @(posedge CLOCK_I)
	begin
		if (SRST_I)
			stack_ptr <= CRS_RST_WORD;
		else if (ex_wr && EXEC_WR_I.sel == CRS_IDX_STACK)
			stack_ptr <= EXEC_WR_I.data;
		else if (bus_wr && REG_ADDR_I == CRS_IDX_STACK)
			stack_ptr <= REG_WDATA_I;
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (SRST_I)
			dbank <= CRS_RST_BANK;
		else if (ex_wr && EXEC_WR_I.sel == CRS_IDX_DBANK)
			dbank <= EXEC_WR_I.data[7:0];
		else if (bus_wr && REG_ADDR_I == CRS_IDX_DBANK)
			dbank <= REG_WDATA_I[7:0];
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (SRST_I)
			dp_base <= CRS_RST_WORD;
		else if (ex_wr && EXEC_WR_I.sel == CRS_IDX_DPBASE)
			dp_base <= EXEC_WR_I.data;
		else if (bus_wr && REG_ADDR_I == CRS_IDX_DPBASE)
			dp_base <= REG_WDATA_I;
	end

	//--------------------------------------------------------------------------
	// Program address: counter and bank move as one 24-bit value
	//--------------------------------------------------------------------------
	// Sign extension lets a branch carry or borrow move the bank by exactly one
	assign br_ext = {{8{BR_OFFSET_I[15]}}, BR_OFFSET_I};

	always_comb
	begin
		next_prog = {pbank, iptr};
		if (BR_APPLY_I)
			next_prog = {pbank, iptr} + br_ext;
		else if (PC_INC_I)
			next_prog = {pbank, iptr} + 24'h000001;
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (SRST_I)
		begin
			iptr  <= CRS_RST_WORD;
			pbank <= CRS_RST_BANK;
		end
		else if (ex_wr && EXEC_WR_I.sel == CRS_IDX_IPTR)
			iptr <= EXEC_WR_I.data;
		else if (ex_wr && EXEC_WR_I.sel == CRS_IDX_PBANK)
			pbank <= EXEC_WR_I.data[7:0];
		else if (BR_APPLY_I || PC_INC_I)
		begin
			iptr  <= next_prog[15:0];
			pbank <= next_prog[23:16];
		end
		else if (bus_wr && REG_ADDR_I == CRS_IDX_IPTR)
			iptr <= REG_WDATA_I;
		else if (bus_wr && REG_ADDR_I == CRS_IDX_PBANK)
			pbank <= REG_WDATA_I[7:0];
	end

	//--------------------------------------------------------------------------
	// Processor status
	//--------------------------------------------------------------------------
	// Order: plain writes, ALU results, clears, sets, interrupt accept last so
	// a hardware set is never lost to a clear in the same cycle.
	always_comb
	begin
		next_pstat = pstat;
		if (ex_wr && EXEC_WR_I.sel == CRS_IDX_PSTAT)
			next_pstat = EXEC_WR_I.data[10:0];
		else if (bus_wr && REG_ADDR_I == CRS_IDX_PSTAT)
			next_pstat = REG_WDATA_I[10:0];
		if (FLAG_UPD_I.carry_we)
			next_pstat[CRS_PS_C] = FLAG_UPD_I.carry;
		if (FLAG_UPD_I.nz_we)
		begin
			next_pstat[CRS_PS_Z] = flag_m ? (FLAG_UPD_I.result[7:0] == 8'h00)
				: (FLAG_UPD_I.result == 16'h0000);
			next_pstat[CRS_PS_N] = flag_m ? FLAG_UPD_I.result[7]
				: FLAG_UPD_I.result[15];
		end
		if (FLAG_UPD_I.ovf_we)
			next_pstat[CRS_PS_V] = FLAG_UPD_I.ovf;
		next_pstat[7:0] = next_pstat[7:0] & ~PS_OP_I.clr_mask;
		if (PS_OP_I.clear_carry_instruction)
			next_pstat[CRS_PS_C] = 1'b0;
		if (PS_OP_I.clear_irq_disable_instruction)
			next_pstat[CRS_PS_I] = 1'b0;
		next_pstat[7:0] = next_pstat[7:0] | PS_OP_I.set_mask;
		if (PS_OP_I.set_carry_instruction)
			next_pstat[CRS_PS_C] = 1'b1;
		if (PS_OP_I.set_irq_disable_instruction)
			next_pstat[CRS_PS_I] = 1'b1;
		if (IRQ_ACCEPT_I)
			next_pstat[CRS_PS_I] = 1'b1;
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (SRST_I)
			pstat <= CRS_RST_PSTAT;
		else
			pstat <= next_pstat;
	end

	//--------------------------------------------------------------------------
	// Interrupt gate and branch test
	//--------------------------------------------------------------------------
	always_ff @(posedge CLOCK_I)
	begin
		if (SRST_I)
			IRQ_GRANT_O <= 1'b0;
		else
			IRQ_GRANT_O <= IRQ_NMASK_I || (IRQ_REQ_I && !pstat[CRS_PS_I]);
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (SRST_I)
			BR_TAKEN_O <= 1'b0;
		else if (!BR_TEST_I)
			BR_TAKEN_O <= 1'b0;
		else
			case (BR_COND_I)
				CRS_BR_CARRY: BR_TAKEN_O <= pstat[CRS_PS_C] == BR_POL_I;
				CRS_BR_ZERO:  BR_TAKEN_O <= pstat[CRS_PS_Z] == BR_POL_I;
				CRS_BR_OVF:   BR_TAKEN_O <= pstat[CRS_PS_V] == BR_POL_I;
				CRS_BR_NEG:   BR_TAKEN_O <= pstat[CRS_PS_N] == BR_POL_I;
				default:      BR_TAKEN_O <= 1'b0;
			endcase
	end

	//--------------------------------------------------------------------------
	// Address generation
	//--------------------------------------------------------------------------
	logic [15:0] idx_x_eff;
	logic [15:0] idx_y_eff;
	logic [23:0] next_ea;

	// In 8-bit index mode only the low byte takes part in the sum
	assign idx_x_eff = flag_x ? {8'h00, index1[7:0]} : index1;
	assign idx_y_eff = flag_x ? {8'h00, index2[7:0]} : index2;

	always_comb
	begin
		next_ea = 24'h000000;
		case (AGEN_I.mode)
			CRS_AG_IDX_X:     next_ea = AGEN_I.base + {8'h00, idx_x_eff};
			CRS_AG_IDX_Y:     next_ea = AGEN_I.base + {8'h00, idx_y_eff};
			CRS_AG_BLK_SRC:   next_ea = {AGEN_I.bank, index1};
			CRS_AG_BLK_DST:   next_ea = {AGEN_I.bank, index2};
			CRS_AG_DIRECT:    next_ea = {8'h00, dp_base} + {16'h0000, AGEN_I.offset};
			CRS_AG_DATA_BANK: next_ea = {dbank, AGEN_I.base[15:0]};
			CRS_AG_STACK_REL: next_ea = {8'h00, stack_ptr} + {16'h0000, AGEN_I.offset};
			default:          next_ea = 24'h000000;
		endcase
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (SRST_I)
		begin
			EA_O       <= 24'h000000;
			EA_VALID_O <= 1'b0;
			DP_SLOW_O  <= 1'b0;
		end
		else
		begin
			EA_O       <= AGEN_I.en ? next_ea : EA_O;
			EA_VALID_O <= AGEN_I.en;
			DP_SLOW_O  <= AGEN_I.en && AGEN_I.mode == CRS_AG_DIRECT
				&& dp_base[7:0] != CRS_DP_FAST_LOW;
		end
	end

	//--------------------------------------------------------------------------
	// Software read port
	//--------------------------------------------------------------------------
	always_ff @(posedge CLOCK_I)
	begin
		if (SRST_I)
			REG_RDATA_O <= 16'h0000;
		else if (!REG_RE_I)
			REG_RDATA_O <= 16'h0000;
		else
			case (REG_ADDR_I)
				CRS_IDX_ACC_PRI: REG_RDATA_O <= acc_pri;
				CRS_IDX_ACC_SEC: REG_RDATA_O <= acc_sec;
				CRS_IDX_INDEX1:  REG_RDATA_O <= index1;
				CRS_IDX_INDEX2:  REG_RDATA_O <= index2;
				CRS_IDX_STACK:   REG_RDATA_O <= stack_ptr;
				CRS_IDX_IPTR:    REG_RDATA_O <= iptr;
				CRS_IDX_PBANK:   REG_RDATA_O <= {8'h00, pbank};
				CRS_IDX_DBANK:   REG_RDATA_O <= {8'h00, dbank};
				CRS_IDX_DPBASE:  REG_RDATA_O <= dp_base;
				CRS_IDX_PSTAT:   REG_RDATA_O <= {5'h00, pstat};
				default:         REG_RDATA_O <= 16'h0000;
			endcase
	end

	// View is a bundle of flip-flops, no logic in between
	assign STATE_O = '{acc_pri, acc_sec, index1, index2, stack_ptr, iptr,
		pbank, dbank, dp_base, pstat};

	//--------------------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------------------
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (SRST_I);

	logic quiet_prog;
	assign quiet_prog = !ex_wr && !bus_wr;

	AST_ACC_NARROW: assert property (
		ex_wr && EXEC_WR_I.sel == CRS_IDX_ACC_PRI && flag_m
		|=> acc_pri[15:8] == $past(acc_pri[15:8]) && acc_pri[7:0] == $past(EXEC_WR_I.data[7:0]))
		else $error("narrow accumulator write disturbed upper byte");
	AST_IDX_NARROW: assert property (
		ex_wr && EXEC_WR_I.sel == CRS_IDX_INDEX2 && flag_x
		|=> index2[15:8] == $past(index2[15:8]))
		else $error("narrow index write disturbed upper byte");
	AST_PC_CARRY: assert property (
		PC_INC_I && !BR_APPLY_I && quiet_prog && iptr == 16'hFFFF
		|=> iptr == 16'h0000 && pbank == $past(pbank) + 8'h01)
		else $error("program bank missed counter carry");
	AST_BR_BANK: assert property (
		BR_APPLY_I && quiet_prog
		|=> {pbank, iptr} == $past({pbank, iptr}) + $past(br_ext))
		else $error("branch did not carry into program bank");
	AST_BLK_SRC: assert property (
		AGEN_I.en && AGEN_I.mode == CRS_AG_BLK_SRC
		|=> EA_VALID_O && EA_O == {$past(AGEN_I.bank), $past(index1)})
		else $error("block source address wrong");
	AST_DP_SPAN: assert property (
		AGEN_I.en && AGEN_I.mode == CRS_AG_DIRECT && dp_base >= CRS_DP_SPAN_BASE
		&& AGEN_I.offset == 8'hFF |=> EA_O[23:16] == 8'h01)
		else $error("direct page did not cross into bank 1");
	AST_DP_SLOW: assert property (
		AGEN_I.en && AGEN_I.mode == CRS_AG_DIRECT && dp_base[7:0] == CRS_DP_FAST_LOW
		|=> !DP_SLOW_O)
		else $error("aligned direct page flagged slow");
	AST_IRQ_BLOCK: assert property (
		pstat[CRS_PS_I] && !IRQ_NMASK_I |=> !IRQ_GRANT_O)
		else $error("maskable interrupt passed while disabled");
	AST_IRQ_SETI: assert property (
		IRQ_ACCEPT_I |=> pstat[CRS_PS_I])
		else $error("interrupt accept did not set disable flag");
	AST_ZERO: assert property (
		FLAG_UPD_I.nz_we && !flag_m && FLAG_UPD_I.result == 16'h0000
		&& PS_OP_I.clr_mask[CRS_PS_Z] == 1'b0 |=> pstat[CRS_PS_Z])
		else $error("zero flag not set on zero result");
	AST_CLC: assert property (
		PS_OP_I.clear_carry_instruction && !PS_OP_I.set_carry_instruction
		&& !PS_OP_I.set_mask[CRS_PS_C] |=> !pstat[CRS_PS_C])
		else $error("carry not cleared");

	COV_PC_WRAP: cover property (PC_INC_I && iptr == 16'hFFFF);
	COV_BR_BACK: cover property (BR_APPLY_I && BR_OFFSET_I[15] ##1 BR_TAKEN_O == 1'b0);
	COV_IRQ_ACC: cover property (IRQ_REQ_I && !pstat[CRS_PS_I] ##1 IRQ_ACCEPT_I);
	COV_DP_SLOW: cover property (DP_SLOW_O);

endmodule : crs_cpu_register_set

// ---- sim/crs_exec_model.sv ----
// Execution-side stand-in that drives the core ports of the register set
`timescale 1ns/1ps

module crs_exec_model
	import crs_pkg::*;
(
	input  wire logic    clock_i,  // Core clock
	output crs_wr_t      wr_o,     // Register write
	output crs_flag_t    flag_o,   // ALU flag results
	output crs_psop_t    psop_o,   // Status bit instructions
	output logic         inc_o,    // Program step
	output logic         bra_o,    // Branch apply
	output logic [15:0]  off_o,    // Branch offset
	output crs_br_cond_t cond_o,   // Flag under test
	output logic         pol_o,    // Taking polarity
	output logic         test_o,   // Branch test
	output crs_agen_t    agen_o,   // Address request
	output logic         req_o,    // Maskable pending
	output logic         nm_o,     // Unmaskable pending
	output logic         acc_o     // Interrupt taken
);
	initial
	begin
		{wr_o, flag_o, psop_o, inc_o, bra_o, off_o} = '0;
		cond_o = CRS_BR_CARRY;
		{pol_o, test_o, agen_o, req_o, nm_o, acc_o} = '0;
	end

	// -------------------------------------------------
	// Each request is held over exactly one sampling edge, except the interrupt pending levels
	// -------------------------------------------------
	task automatic wr(input logic [3:0] s, input logic [15:0] d);
		@(posedge clock_i);
		wr_o <= {1'b1, s, d};
		@(posedge clock_i);
		wr_o <= '0;
		#1;
	endtask : wr

	task automatic flg(input logic cw, c, nw, input logic [15:0] r);
		@(posedge clock_i);
		flag_o <= {cw, c, nw, r, 2'b00};
		@(posedge clock_i);
		flag_o <= '0;
		#1;
	endtask : flg

	task automatic ps(input logic [3:0] op, input logic [7:0] sm, cm);
		@(posedge clock_i);
		psop_o <= {op, sm, cm};
		@(posedge clock_i);
		psop_o <= '0;
		#1;
	endtask : ps

	task automatic pc(input logic i, b, input logic [15:0] o);
		@(posedge clock_i);
		{inc_o, bra_o, off_o} <= {i, b, o};
		@(posedge clock_i);
		{inc_o, bra_o} <= 2'b00;
		#1;
	endtask : pc

	task automatic br(input crs_br_cond_t c, input logic p);
		@(posedge clock_i);
		cond_o <= c;
		{pol_o, test_o} <= {p, 1'b1};
		@(posedge clock_i);
		test_o <= 1'b0;
		#1;
	endtask : br

	task automatic ag(input crs_agen_mode_t md, input logic [23:0] b,
		input logic [7:0] bk, o);
		@(posedge clock_i);
		agen_o <= {1'b1, md, b, bk, o};
		@(posedge clock_i);
		agen_o.en <= 1'b0;
		#1;
	endtask : ag

	// Pending levels persist; only the acceptance is a pulse
	task automatic irq(input logic r, n, a);
		@(posedge clock_i);
		{req_o, nm_o, acc_o} <= {r, n, a};
		@(posedge clock_i);
		acc_o <= 1'b0;
		#1;
	endtask : irq
endmodule : crs_exec_model

// ---- sim/crs_cpu_register_set_bench.sv ----
// Self-checking bench for the CPU register set
`timescale 1ns/1ps

module crs_cpu_register_set_bench
	import crs_pkg::*;
;
	logic         clk = 1'b0;
	logic         srst = 1'b1;
	logic [3:0]   ra = '0;
	logic [15:0]  wd = '0;
	logic         we = 1'b0;
	logic         re = 1'b0;
	logic [15:0]  rdat, off;
	crs_wr_t      ew;
	crs_flag_t    fu;
	crs_psop_t    po;
	crs_agen_t    agr;
	crs_br_cond_t cnd;
	crs_state_t   st;
	logic         inc, bra, pol, tst, rq, nm, ac, tk, eav, slow, gr;
	logic [23:0]  ea;
	int           err_count = 0;
	int           num_checks = 0;
	int           bp[4] = '{0, 1, 6, 7};

	always #2 clk = ~clk;

	crs_exec_model m (.clock_i(clk), .wr_o(ew), .flag_o(fu), .psop_o(po), .inc_o(inc),
		.bra_o(bra), .off_o(off), .cond_o(cnd), .pol_o(pol), .test_o(tst), .agen_o(agr),
		.req_o(rq), .nm_o(nm), .acc_o(ac));

	crs_cpu_register_set dut (.CLOCK_I(clk), .SRST_I(srst), .REG_ADDR_I(ra),
		.REG_WDATA_I(wd), .REG_WE_I(we), .REG_RE_I(re), .REG_RDATA_O(rdat),
		.EXEC_WR_I(ew), .FLAG_UPD_I(fu), .PS_OP_I(po), .PC_INC_I(inc), .BR_APPLY_I(bra),
		.BR_OFFSET_I(off), .BR_COND_I(cnd), .BR_POL_I(pol), .BR_TEST_I(tst),
		.BR_TAKEN_O(tk), .AGEN_I(agr), .EA_O(ea), .EA_VALID_O(eav), .DP_SLOW_O(slow),
		.IRQ_REQ_I(rq), .IRQ_NMASK_I(nm), .IRQ_ACCEPT_I(ac), .IRQ_GRANT_O(gr),
		.STATE_O(st));

	// -------------------------------------------------
	// Shared tasks
	// -------------------------------------------------
	task automatic chk(input string n, input logic [23:0] g, e);
		num_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	task automatic rw(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		{ra, wd, we} <= {a, d, 1'b1};
		@(posedge clk);
		we <= 1'b0;
		#1;
	endtask : rw

	task automatic rc(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		{ra, re} <= {a, 1'b1};
		@(posedge clk);
		re <= 1'b0;
		#1;
		chk("rdata", rdat, e);
	endtask : rc

	task automatic agc(input crs_agen_mode_t md, input logic [23:0] b,
		input logic [7:0] bk, o, input logic [23:0] e, input logic s);
		m.ag(md, b, bk, o);
		chk("ea", ea, e);
		chk("ea_valid", eav, 1'b1);
		chk("dp_slow", slow, s);
	endtask : agc

	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		stop_test();
	end

	// -------------------------------------------------
	// Main sequence
	// -------------------------------------------------
	initial
	begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		rc(CRS_IDX_PSTAT, 16'h0004);
		@(posedge clk);
		#1;
		chk("rdata_idle", rdat, 24'h0);
		for (int i = 0; i < 11; i++)
		begin
			rw(4'(i), 16'hFFFF);
			rc(4'(i), i inside {6, 7} ? 16'h00FF : i == 9 ? 16'h07FF : i == 10 ? 16'h0 : 16'hFFFF);
		end
		rw(CRS_IDX_PSTAT, 16'h0000);
		$display("register port done");
		m.ps(4'b0000, 8'h20, 8'h00);
		m.wr(CRS_IDX_ACC_PRI, 16'h1234);
		chk("acc_pri", st.primary_accumulator, 16'hFF34);
		m.wr(CRS_IDX_ACC_SEC, 16'h1234);
		chk("acc_sec", st.secondary_accumulator, 16'hFF34);
		m.flg(1'b0, 1'b0, 1'b1, 16'h0100);
		chk("zero_narrow", st.processor_status[CRS_PS_Z], 1'b1);
		m.ps(4'b0000, 8'h10, 8'h00);
		m.wr(CRS_IDX_INDEX1, 16'h5678);
		chk("index1", st.first_index, 16'hFF78);
		m.wr(CRS_IDX_INDEX2, 16'h5678);
		chk("index2", st.second_index, 16'hFF78);
		m.ps(4'b0000, 8'h00, 8'h30);
		m.wr(CRS_IDX_ACC_PRI, 16'h1234);
		chk("acc_wide", st.primary_accumulator, 16'h1234);
		m.flg(1'b0, 1'b0, 1'b1, 16'h0100);
		chk("zero_wide", st.processor_status[CRS_PS_Z], 1'b0);
		m.flg(1'b0, 1'b0, 1'b1, 16'h0000);
		chk("zero_hit", st.processor_status[CRS_PS_Z], 1'b1);
		$display("width done");
		rw(CRS_IDX_PBANK, 16'h0012);
		m.pc(1'b1, 1'b0, 16'h0000);
		chk("pc_inc", {st.program_bank, st.instruction_pointer}, 24'h130000);
		m.pc(1'b0, 1'b1, 16'hFFF0);
		chk("pc_back", {st.program_bank, st.instruction_pointer}, 24'h12FFF0);
		m.pc(1'b0, 1'b1, 16'h0020);
		chk("pc_fwd", {st.program_bank, st.instruction_pointer}, 24'h130010);
		$display("program address done");
		rw(CRS_IDX_INDEX1, 16'h8001);
		rw(CRS_IDX_INDEX2, 16'h4002);
		rw(CRS_IDX_DPBASE, 16'hFF80);
		rw(CRS_IDX_DBANK, 16'h0044);
		rw(CRS_IDX_STACK, 16'h0100);
		agc(CRS_AG_IDX_X, 24'h12FFFF, 8'h00, 8'h00, 24'h138000, 1'b0);
		agc(CRS_AG_IDX_Y, 24'h000010, 8'h00, 8'h00, 24'h004012, 1'b0);
		agc(CRS_AG_BLK_SRC, 24'h0, 8'h7E, 8'h00, 24'h7E8001, 1'b0);
		agc(CRS_AG_BLK_DST, 24'h0, 8'h3C, 8'h00, 24'h3C4002, 1'b0);
		agc(CRS_AG_DIRECT, 24'h0, 8'h00, 8'h90, 24'h010010, 1'b1);
		agc(CRS_AG_DIRECT, 24'h0, 8'h00, 8'hFF, 24'h01007F, 1'b1);
		agc(CRS_AG_DATA_BANK, 24'h335566, 8'h00, 8'h00, 24'h445566, 1'b0);
		agc(CRS_AG_STACK_REL, 24'h0, 8'h00, 8'h05, 24'h000105, 1'b0);
		rw(CRS_IDX_DPBASE, 16'h0100);
		agc(CRS_AG_DIRECT, 24'h0, 8'h00, 8'h10, 24'h000110, 1'b0);
		$display("address generation done");
		m.flg(1'b1, 1'b1, 1'b0, 16'h0000);
		chk("carry_alu", st.processor_status[CRS_PS_C], 1'b1);
		m.ps(4'b0100, 8'h00, 8'h00);
		chk("carry_clr", st.processor_status[CRS_PS_C], 1'b0);
		m.ps(4'b1000, 8'h00, 8'h00);
		chk("carry_set", st.processor_status[CRS_PS_C], 1'b1);
		m.ps(4'b0000, 8'h00, 8'h01);
		chk("carry_mclr", st.processor_status[CRS_PS_C], 1'b0);
		m.ps(4'b0000, 8'h03, 8'h00);
		chk("cz_mset", st.processor_status[1:0], 2'b11);
		m.flg(1'b1, 1'b0, 1'b0, 16'h0000);
		chk("carry_alu0", st.processor_status[CRS_PS_C], 1'b0);
		for (int i = 0; i < 4; i++)
		begin
			rw(CRS_IDX_PSTAT, 16'h0001 << bp[i]);
			for (int j = 0; j < 4; j++)
			begin
				m.br(crs_br_cond_t'(j), 1'b1);
				chk("branch", tk, i == j);
			end
		end
		m.br(CRS_BR_NEG, 1'b0);
		chk("branch_pol", tk, 1'b0);
		$display("flags done");
		m.irq(1'b1, 1'b0, 1'b0);
		chk("grant_open", gr, 1'b1);
		m.ps(4'b0010, 8'h00, 8'h00);
		chk("idis_set", st.processor_status[CRS_PS_I], 1'b1);
		m.irq(1'b1, 1'b0, 1'b0);
		chk("grant_mask", gr, 1'b0);
		m.irq(1'b1, 1'b1, 1'b0);
		chk("grant_nmask", gr, 1'b1);
		m.ps(4'b0001, 8'h00, 8'h00);
		chk("idis_clr", st.processor_status[CRS_PS_I], 1'b0);
		m.irq(1'b0, 1'b0, 1'b1);
		chk("idis_accept", st.processor_status[CRS_PS_I], 1'b1);
		m.ps(4'b0000, 8'h00, 8'h04);
		chk("idis_mclr", st.processor_status[CRS_PS_I], 1'b0);
		m.ps(4'b0000, 8'h04, 8'h00);
		chk("idis_mset", st.processor_status[CRS_PS_I], 1'b1);
		$display("interrupt done");
		stop_test();
	end
endmodule : crs_cpu_register_set_bench
